/* shared/csio_regs.vh */
// register offsets, field positions, reset values and timing constants
`ifndef CSIO_REGS_VH
`define CSIO_REGS_VH

// ==================================================================
// register byte offsets
`define CSIO_TXBUF_OFS   8'h00
`define CSIO_RXBUF_OFS   8'h04
`define CSIO_DIV_OFS     8'h08
`define CSIO_MODE_OFS    8'h0C
`define CSIO_CTL0_OFS    8'h10
`define CSIO_CTL1_OFS    8'h14
`define CSIO_COMMON_OFS  8'h18
`define CSIO_IRQST_OFS   8'h1C
`define CSIO_IRQMSK_OFS  8'h20

// ==================================================================
// serial_mode_register fields
`define CSIO_MODE_SMD_LO   0
`define CSIO_MODE_CKSRC    3
`define CSIO_MODE_SYNC     3'b001
// serial_control_zero fields
`define CSIO_C0_CNT_LO     0
`define CSIO_C0_TX_SHIFT_EMPTY_FLAG      3
`define CSIO_C0_ODRAIN     5
`define CSIO_C0_EDGE       6
`define CSIO_C0_MSBF       7
// serial_control_one fields
`define CSIO_C1_TXEN       0
`define CSIO_C1_TXBE       1
`define CSIO_C1_RXEN       2
`define CSIO_C1_RXDONE     3
// serial_common_control fields
`define CSIO_CC_TXIRS      0
`define CSIO_CC_CONTRX     2
// receive_buffer overrun bit
`define CSIO_RB_OVR        12
// interrupt status bits
`define CSIO_IRQ_TX        0
`define CSIO_IRQ_RX        1
`define CSIO_IRQ_OVR       2

// ==================================================================
// reset values and timing
`define CSIO_RST_C0        8'h08
`define CSIO_RST_C1        8'h02
`define CSIO_PRE_F8        8'h07
`define CSIO_PRE_F32       8'h1F
`define CSIO_OVR_BIT       4'h7
`define CSIO_WORD_BITS     4'h8

`endif

/* hdl/csio_clkgen.v */
// internal transfer clock half-period tick generator
`timescale 1ns/1ps
module csio_clkgen (
  // clock and reset
  input  wire       CLK,
  input  wire       RESETN,
  // control
  input  wire       RUN,
  input  wire [1:0] CNT_SEL,
  input  wire [7:0] DIV,
  // half-period tick
  output reg        TICK
);
`include "csio_regs.vh"

  reg [7:0] pre_q;
  reg [7:0] div_q;
  reg [7:0] pre_max;

  always @* begin
    case (CNT_SEL)
      2'b00:   pre_max = 8'h00;
      2'b01:   pre_max = `CSIO_PRE_F8;
      default: pre_max = `CSIO_PRE_F32;
    endcase
  end

  // each tick is one half period: (n+1) counts of fi
  always @(posedge CLK) begin
    TICK <= 1'b0;
    if (!RESETN || !RUN) begin
      pre_q <= 8'h00;
      div_q <= 8'h00;
    end else if (pre_q >= pre_max) begin
      pre_q <= 8'h00;
      if (div_q >= DIV) begin
        div_q <= 8'h00;
        TICK  <= 1'b1;
      end else begin
        div_q <= div_q + 8'h01;
      end
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end
endmodule // csio_clkgen

/* hdl/csio_top.v */
// clock synchronous serial channel with axi4-lite register slave
// Operation
// R1 - each transfer moves exactly one eight-bit word
// R2 - internal clock is fi/(2(n+1)), fi from f1, f8 or f32
// R3 - clock source bit 1 takes clock pin as input, 0 drives it
// R4 - transmit starts only with tx enabled and buffer holding a word
// R5 - receive needs rx enable, tx enable and a word in tx buffer
// R6 - tx interrupt at buffer-to-shift move or at shift completion
// R7 - rx interrupt when completed word moves into receive buffer
// R8 - overrun when unread buffer and seventh bit of new word arrive
// R9 - on overrun the rx interrupt request stays unchanged
// R10 - edge select picks drive and sample clock edges
// R11 - external clock idles high for edge 0, low for edge 1
// R12 - bit order select gives lsb first or msb first
// R13 - continuous receive: reading receive buffer re-arms reception
// R14 - software writes zero to unused control bits
// R15 - data out high, or released when open drain, until first transfer
// R16 - receive-only still shifts dummy transmit word out
// R17 - readable flags: tx buffer empty, shift empty, rx done, overrun
// R18 - software writes mode field 001 before enabling
// R19 - tx buffer empty sets on move to shift, clears on write
`timescale 1ns/1ps
module csio_top (
  // clock and reset
  input  wire        CLK,
  input  wire        RESETN,
  // axi4-lite write
  input  wire [7:0]  AWADDR,
  input  wire        AWVALID,
  output reg         AWREADY,
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  input  wire        WVALID,
  output reg         WREADY,
  output reg  [1:0]  BRESP,
  output reg         BVALID,
  input  wire        BREADY,
  // axi4-lite read
  input  wire [7:0]  ARADDR,
  input  wire        ARVALID,
  output reg         ARREADY,
  output reg  [31:0] RDATA,
  output reg  [1:0]  RRESP,
  output reg         RVALID,
  input  wire        RREADY,
  // serial pins
  output reg         SDO,
  output reg         SDO_OE,
  input  wire        SDI,
  input  wire        SCK_I,
  output reg         SCK_O,
  output reg         SCK_OE,
  // interrupt
  output reg         IRQ
);
`include "csio_regs.vh"

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a[1:0] == 2'b00) && (a <= `CSIO_IRQMSK_OFS);
    end
  endfunction

  // next data bit on the output pin for the chosen bit order
  function tx_bit;
    input [7:0] w;
    input       msb;
    begin
      tx_bit = msb ? w[7] : w[0];
    end
  endfunction

  // ================================================================
  // registers
  reg  [7:0] txbuf_q, div_q, mode_q, c0_q, c1_q, cc_q;
  reg  [7:0] rxbuf_q;
  reg        ovr_q;
  reg  [2:0] irqst_q, irqmsk_q;
  reg        started_q;
  reg  [7:0] tsh_q, rsh_q;
  reg  [3:0] cnt_q;
  reg        busy_q, phase_q;
  reg        sck_q, sck_s_q, sck_p_q;
  reg        rx_arm_q, rx_cur_q;
  reg        aw_q, w_q;
  reg  [7:0] awa_q;
  reg [31:0] wd_q;

  wire ext_clk  = mode_q[`CSIO_MODE_CKSRC];
  wire edge_sel = c0_q[`CSIO_C0_EDGE];
  wire msbf     = c0_q[`CSIO_C0_MSBF];
  wire odrain   = c0_q[`CSIO_C0_ODRAIN];
  wire tx_en    = c1_q[`CSIO_C1_TXEN];
  wire txbe     = c1_q[`CSIO_C1_TXBE];
  wire rx_en    = c1_q[`CSIO_C1_RXEN];
  wire rx_done  = c1_q[`CSIO_C1_RXDONE];
  wire sync_md  = mode_q[2:0] == `CSIO_MODE_SYNC;
  wire idle_lvl = ~edge_sel;

  // ================================================================
  // axi write and read handshake
  wire wr_go = aw_q && w_q && !BVALID;
  wire rd_go = ARVALID && ARREADY;
  wire [7:0] wsel = awa_q;

  always @(posedge CLK) begin
    if (!RESETN) begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      aw_q    <= 1'b0;
      w_q     <= 1'b0;
      awa_q   <= 8'h00;
      wd_q    <= 32'h0000_0000;
      BVALID  <= 1'b0;
      BRESP   <= 2'b00;
    end else begin
      AWREADY <= !aw_q && !AWREADY && AWVALID;
      WREADY  <= !w_q && !WREADY && WVALID;
      if (AWVALID && AWREADY) begin
        aw_q  <= 1'b1;
        awa_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_q  <= 1'b1;
        wd_q <= WDATA & {{8{WSTRB[3]}}, {8{WSTRB[2]}},
                         {8{WSTRB[1]}}, {8{WSTRB[0]}}};
      end
      if (wr_go) begin
        aw_q   <= 1'b0;
        w_q    <= 1'b0;
        BVALID <= 1'b1;
        BRESP  <= is_mapped(wsel) ? 2'b00 : 2'b10;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // a buffer write takes effect in the cycle the response is issued
  wire wr_txbuf = wr_go && (wsel == `CSIO_TXBUF_OFS);
  wire rd_rxbuf = rd_go && (ARADDR == `CSIO_RXBUF_OFS);

  // ================================================================
  // transfer clock
  wire tick;
  csio_clkgen u_clkgen (
    .CLK     (CLK),
    .RESETN  (RESETN),
    .RUN     (busy_q && !ext_clk),
    .CNT_SEL (c0_q[1:0]),
    .DIV     (div_q),
    .TICK    (tick)
  );

  // external clock is synchronous; edge detection on registered copy
  wire ext_rise = sck_s_q && !sck_p_q;
  wire ext_fall = !sck_s_q && sck_p_q;
  // leading edge leaves idle level, trailing edge returns to it
  wire lead  = ext_clk ? (edge_sel ? ext_rise : ext_fall)    // [R11]
                       : (tick && !phase_q);
  wire trail = ext_clk ? (edge_sel ? ext_fall : ext_rise)
                       : (tick && phase_q);
  // drive on leading edge, sample on trailing edge [R10]

  wire can_start = sync_md && tx_en && !txbe && !busy_q;      // [R4]
  // receive rides on a transmit; the word shifted out is then a dummy
  wire rx_ok = rx_en;                                         // [R5]
  wire last  = trail && cnt_q == `CSIO_WORD_BITS - 4'h1;      // [R1]
  wire [7:0] rx_word = msbf ? {rsh_q[6:0], SDI}
                            : {SDI, rsh_q[7:1]};              // [R12]
  wire ovr_hit = busy_q && rx_cur_q && rx_done && trail &&
                 cnt_q == `CSIO_OVR_BIT - 4'h1;               // [R8]
  wire tx_ev = (can_start && !cc_q[`CSIO_CC_TXIRS]) ||
               (last && cc_q[`CSIO_CC_TXIRS]);                // [R6]
  // an overrun word never raises the receive request [R9]
  wire rx_ev = last && rx_cur_q && !ovr_q && !ovr_hit;

  // ================================================================
  // shift engine
  always @(posedge CLK) begin
    if (!RESETN) begin
      tsh_q     <= 8'h00;
      rsh_q     <= 8'h00;
      cnt_q     <= 4'h0;
      busy_q    <= 1'b0;
      phase_q   <= 1'b0;
      sck_q     <= 1'b1;
      sck_s_q   <= 1'b1;
      sck_p_q   <= 1'b1;
      rx_cur_q  <= 1'b0;
      started_q <= 1'b0;
    end else begin
      sck_s_q <= SCK_I;
      sck_p_q <= sck_s_q;
      if (!busy_q)
        sck_q <= idle_lvl;
      if (can_start) begin
        tsh_q     <= txbuf_q;                                 // [R19]
        busy_q    <= 1'b1;
        cnt_q     <= 4'h0;
        phase_q   <= 1'b0;
        started_q <= 1'b1;                                    // [R15]
        rx_cur_q  <= rx_ok;                                   // [R5]
      end else if (busy_q) begin
        if (tick)
          phase_q <= ~phase_q;
        if (lead && !ext_clk)
          sck_q <= ~idle_lvl;
        // the first bit is on the pin before the first leading edge; later bits
        // move on the leading edge so the far side never sees data
        // change at its sampling edge [R10]
        if (lead && cnt_q != 4'h0)
          tsh_q <= msbf ? {tsh_q[6:0], 1'b0} : {1'b0, tsh_q[7:1]};
        if (trail) begin
          if (!ext_clk)
            sck_q <= idle_lvl;
          rsh_q <= rx_word;
          cnt_q <= cnt_q + 4'h1;
          if (last)
            busy_q <= 1'b0;
        end
      end
    end
  end

  // ================================================================
  // pin outputs
  always @(posedge CLK) begin
    if (!RESETN) begin
      SDO    <= 1'b1;
      SDO_OE <= 1'b0;
      SCK_O  <= 1'b1;
      SCK_OE <= 1'b0;
    end else begin
      // dummy word still shifts out during receive-only [R16]
      SDO    <= (started_q || can_start) ?
                tx_bit(tsh_q, msbf) : 1'b1;                   // [R15]
      // open drain only pulls low; a one is left to the pull-up
      SDO_OE <= sync_md && (!odrain || ((started_q || can_start) &&
                !tx_bit(tsh_q, msbf)));
      SCK_O  <= sck_q;                                        // [R2]
      SCK_OE <= sync_md && !ext_clk;                          // [R3]
    end
  end

  // ================================================================
  // register file
  wire [7:0] wb = wd_q[7:0];
  always @(posedge CLK) begin
    if (!RESETN) begin
      txbuf_q  <= 8'h00;
      div_q    <= 8'h00;
      mode_q   <= 8'h00;
      c0_q     <= `CSIO_RST_C0;
      c1_q     <= `CSIO_RST_C1;
      cc_q     <= 8'h00;
      rxbuf_q  <= 8'h00;
      ovr_q    <= 1'b0;
      irqst_q  <= 3'b000;
      irqmsk_q <= 3'b000;
      rx_arm_q <= 1'b0;
    end else begin
      if (wr_go) begin
        case (wsel)
          `CSIO_TXBUF_OFS:  txbuf_q  <= wb;
          `CSIO_DIV_OFS:    div_q    <= wb;
          `CSIO_MODE_OFS:   mode_q   <= wb;                   // [R18]
          `CSIO_CTL0_OFS:   c0_q[7:4] <= wb[7:4];             // [R14]
          `CSIO_COMMON_OFS: cc_q     <= wb;
          `CSIO_IRQMSK_OFS: irqmsk_q <= wb[2:0];
          default: ;
        endcase
        if (wsel == `CSIO_CTL0_OFS)
          c0_q[1:0] <= wb[1:0];
        if (wsel == `CSIO_CTL1_OFS) begin
          c1_q[`CSIO_C1_TXEN] <= wb[`CSIO_C1_TXEN];
          c1_q[`CSIO_C1_RXEN] <= wb[`CSIO_C1_RXEN];
        end
      end
      // tx buffer empty flag: move sets, write clears [R19]
      // an armed continuous receive reuses the buffered word as dummy
      if (can_start)
        c1_q[`CSIO_C1_TXBE] <= 1'b1;
      else if (wr_txbuf || rx_arm_q)                          // [R13]
        c1_q[`CSIO_C1_TXBE] <= 1'b0;
      c0_q[`CSIO_C0_TX_SHIFT_EMPTY_FLAG] <= !(busy_q || can_start);         // [R17]
      // continuous receive: read of buffer arms next reception
      if (rd_rxbuf && cc_q[`CSIO_CC_CONTRX])
        rx_arm_q <= 1'b1;                                     // [R13]
      else if (can_start)
        rx_arm_q <= 1'b0;
      // received word; undefined content simply overwritten on overrun
      if (last && rx_cur_q)
        rxbuf_q <= rx_word;                                   // [R7]
      if (ovr_hit)
        ovr_q <= 1'b1;
      else if (rd_rxbuf)
        ovr_q <= 1'b0;
      if (rx_ev)
        c1_q[`CSIO_C1_RXDONE] <= 1'b1;
      else if (rd_rxbuf)
        c1_q[`CSIO_C1_RXDONE] <= 1'b0;
      // sticky status: set beats write-one-to-clear
      irqst_q <= (irqst_q & ~((wr_go && wsel == `CSIO_IRQST_OFS) ?
                              wb[2:0] : 3'b000))
               | {ovr_hit, rx_ev, tx_ev};                     // [R9]
    end
  end

  // ================================================================
  // read path and interrupt
  reg [31:0] rmux;
  always @* begin
    case (ARADDR)
      `CSIO_TXBUF_OFS:  rmux = {24'h00_0000, txbuf_q};
      `CSIO_RXBUF_OFS:  rmux = {19'h0_0000, ovr_q, 4'h0, rxbuf_q};
      `CSIO_DIV_OFS:    rmux = {24'h00_0000, div_q};
      `CSIO_MODE_OFS:   rmux = {24'h00_0000, mode_q};
      `CSIO_CTL0_OFS:   rmux = {24'h00_0000, c0_q};
      `CSIO_CTL1_OFS:   rmux = {24'h00_0000, c1_q};
      `CSIO_COMMON_OFS: rmux = {24'h00_0000, cc_q};
      `CSIO_IRQST_OFS:  rmux = {29'h0000_0000, irqst_q};
      `CSIO_IRQMSK_OFS: rmux = {29'h0000_0000, irqmsk_q};
      default:          rmux = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK) begin
    if (!RESETN) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= 2'b00;
      IRQ     <= 1'b0;
    end else begin
      ARREADY <= ARVALID && !ARREADY && !RVALID;
      if (rd_go) begin
        RVALID <= 1'b1;
        RDATA  <= rmux;
        RRESP  <= is_mapped(ARADDR) ? 2'b00 : 2'b10;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
      IRQ <= |(irqst_q & irqmsk_q);
    end
  end
endmodule // csio_top

/* tb/csio_checker.sv */
// bus handshake assertions for the clocked serial channel
`timescale 1ns/1ps
module csio_checker (
  // watched ports
  input wire        CLK,
  input wire        RESETN,
  input wire        AWVALID,
  input wire        AWREADY,
  input wire        BVALID,
  input wire        BREADY,
  input wire [1:0]  BRESP,
  input wire        ARVALID,
  input wire        ARREADY,
  input wire        RVALID,
  input wire        RREADY,
  input wire [1:0]  RRESP,
  input wire [31:0] RDATA
);
  // ==========
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  property p_aw_pulse; AWREADY |=> !AWREADY; endproperty
  a_aw_pulse: assert property (p_aw_pulse)
    else $error("awready held");
  property p_b_lat; $rose(AWVALID) |-> ##[1:8] BVALID; endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("write answer late");
  property p_b_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  property p_b_code; BVALID |-> !BRESP[0]; endproperty
  a_b_code: assert property (p_b_code)
    else $error("bad write code");
  property p_ar_pulse; ARREADY |=> !ARREADY; endproperty
  a_ar_pulse: assert property (p_ar_pulse)
    else $error("arready held");
  property p_r_lat; $rose(ARVALID) |-> ##[1:4] RVALID; endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data unstable");
  property p_r_err; RVALID && RRESP == 2'h2 |-> RDATA == 32'h0000_0000;
  endproperty
  a_r_err: assert property (p_r_err)
    else $error("unmapped read not zero");
endmodule // csio_checker

bind csio_top csio_checker u_chk (.CLK, .RESETN, .AWVALID, .AWREADY,
  .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .RVALID, .RREADY,
  .RRESP, .RDATA);

/* tb/csio_peer.sv */
// behavioural serial peer clocked by the channel's transfer clock
`timescale 1ns/1ps
module csio_peer (
  // link
  input wire         sck,
  input wire         sdo,
  output logic       sdi,
  // setup
  input wire         edge_sel,
  input wire         msb_first,
  input wire         load,
  input wire [7:0]   tx_byte,
  output logic [7:0] rx_byte
);
  int tn = 8;
  int rn = 8;
  // folding in the edge select makes the leading edge always a fall
  wire s = sck ^ edge_sel;
  initial sdi = 1'b1;
  always @(posedge load) begin
    tn = 0;
    rn = 0;
  end
  always @(negedge s) if (tn < 8) begin
    sdi = tx_byte[msb_first ? 7 - tn : tn];
    tn++;
  end
  always @(posedge s) if (rn < 8) begin
    rx_byte[msb_first ? 7 - rn : rn] = sdo;
    rn++;
    // after the word the line stops holding the last bit
    if (rn == 8) sdi <= #40 ~sdi;
  end
endmodule // csio_peer

/* tb/test_clocked_serial_io.sv */
// self-checking bench for the clocked serial channel
`timescale 1ns/1ps
`include "csio_regs.vh"
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); \
  end \
end
module test_clocked_serial_io;
  // ==========
  // signals
  logic        CLK, RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        SCK_I, p_load;
  logic [7:0]  AWADDR, ARADDR, p_tx, c0;
  logic [31:0] WDATA, d;
  logic [1:0]  rsp;
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, SDI;
  wire         SDO, SDO_OE, SCK_O, SCK_OE, IRQ;
  wire  [1:0]  BRESP, RRESP;
  wire  [31:0] RDATA;
  wire  [7:0]  p_rx;
  int          n_mismatch, compares, cyc, h, n;
  // control0, byte sent, byte the peer answers
  logic [23:0] rows [4] = '{24'h00_A53C, 24'h41_0FF0, 24'hC2_5A81,
                            24'h80_FF00};
  csio_top u_dut (.CLK, .RESETN, .AWADDR, .AWVALID, .AWREADY, .WDATA,
    .WSTRB(4'hF), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
    .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .SDO, .SDO_OE,
    .SDI, .SCK_I, .SCK_O, .SCK_OE, .IRQ);
  // a released open-drain line reads as the pull-up level
  csio_peer u_peer (.sck(SCK_OE ? SCK_O : SCK_I),
    .sdo(SDO_OE ? SDO : 1'b1), .sdi(SDI), .edge_sel(c0[6]),
    .msb_first(c0[7]), .load(p_load), .tx_byte(p_tx), .rx_byte(p_rx));
  // ==========
  // clock, watchdog, bus tasks
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input [7:0] a, input [31:0] v);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    BREADY <= 1'b0;
    rsp = BRESP;
    @(posedge CLK);
  endtask
  task automatic rd(input [7:0] a);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    RREADY <= 1'b0;
    d = RDATA;
    rsp = RRESP;
    @(posedge CLK);
  endtask
  task automatic poll(input [7:0] a, input int b);
    do begin
      rd(a);
    end while (d[b] !== 1'b1);
  endtask
  task automatic xfer(input [7:0] tx, input [7:0] px);
    p_tx = px;
    p_load = 1'b1;
    #1 p_load = 1'b0;
    wr(`CSIO_TXBUF_OFS, {24'h00_0000, tx});
  endtask
  // ==========
  // tests
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, p_load} = 6'h00;
    {AWADDR, ARADDR, p_tx, c0, WDATA} = 64'h0000_0000_0000_0000;
    RESETN = 1'b0;
    SCK_I = 1'b1;
    repeat (12) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    `CHK(SDO, 1'b1)
    rd(`CSIO_CTL0_OFS);
    `CHK(d[7:0], `CSIO_RST_C0)
    rd(`CSIO_CTL1_OFS);
    `CHK(d[7:0], `CSIO_RST_C1)
    wr(`CSIO_MODE_OFS, 32'h0000_0001);
    wr(`CSIO_DIV_OFS, 32'h0000_0003);
    // a word written while tx is off must wait
    xfer(8'h3C, 8'hC3);
    rd(`CSIO_CTL1_OFS);
    `CHK(d[1], 1'b0)
    repeat (20) @(posedge CLK);
    rd(`CSIO_CTL0_OFS);
    `CHK(d[3], 1'b1)
    `CHK(SDO, 1'b1)
    wr(`CSIO_CTL1_OFS, 32'h0000_0005);
    poll(`CSIO_IRQST_OFS, `CSIO_IRQ_RX);
    rd(`CSIO_RXBUF_OFS);
    `CHK(d[7:0], 8'hC3)
    `CHK(p_rx, 8'h3C)
    rd(`CSIO_CTL1_OFS);
    `CHK(d[1], 1'b1)
    wr(`CSIO_IRQST_OFS, 32'h0000_0007);
    rd(8'h40);
    `CHK({rsp, d}, {2'h2, 32'h0000_0000})
    wr(8'h40, 32'h0000_0001);
    `CHK(rsp, 2'h2)
    $display("start test done");
    for (int i = 0; i < 4; i++) begin
      c0 = rows[i][23:16];
      wr(`CSIO_CTL0_OFS, {24'h00_0000, c0});
      wr(`CSIO_IRQMSK_OFS, {30'h0000_0000, i[0], 1'b0});
      xfer(rows[i][15:8], rows[i][7:0]);
      h = SCK_O;
      while (SCK_O === h) @(posedge CLK);
      n = 0;
      h = SCK_O;
      while (SCK_O === h) begin
        @(posedge CLK);
        n++;
      end
      `CHK(n, (c0[1] ? 32 : c0[0] ? 8 : 1) * 4)
      poll(`CSIO_IRQST_OFS, `CSIO_IRQ_RX);
      `CHK(d[2:0], 3'h3)
      `CHK(IRQ, i[0])
      rd(`CSIO_RXBUF_OFS);
      `CHK(d[7:0], rows[i][7:0])
      `CHK(p_rx, rows[i][15:8])
      wr(`CSIO_IRQST_OFS, 32'h0000_0007);
      `CHK(IRQ, 1'b0)
      $display("row %0d done", i);
    end
    // the second word lands on an unread buffer
    for (int s = 0; s < 2; s++) begin
      wr(`CSIO_IRQST_OFS, 32'h0000_0007);
      wr(`CSIO_COMMON_OFS, 32'(s));
      xfer(8'h96, 8'h69);
      poll(`CSIO_IRQST_OFS, `CSIO_IRQ_TX);
      rd(`CSIO_CTL0_OFS);
      `CHK(d[3], s[0])
      poll(`CSIO_IRQST_OFS, s ? `CSIO_IRQ_OVR : `CSIO_IRQ_RX);
    end
    rd(`CSIO_IRQST_OFS);
    `CHK(d[2:1], 2'h2)
    rd(`CSIO_RXBUF_OFS);
    `CHK(d[12], 1'b1)
    $display("overrun test done");
    // continuous receive: a buffer read alone starts the next word
    wr(`CSIO_IRQST_OFS, 32'h0000_0007);
    wr(`CSIO_COMMON_OFS, 32'h0000_0004);
    p_tx = 8'h5B;
    p_load = 1'b1;
    #1 p_load = 1'b0;
    rd(`CSIO_RXBUF_OFS);
    poll(`CSIO_IRQST_OFS, `CSIO_IRQ_RX);
    wr(`CSIO_COMMON_OFS, 32'h0000_0000);
    rd(`CSIO_RXBUF_OFS);
    `CHK(d[7:0], 8'h5B)
    `CHK(p_rx, 8'h96)
    $display("continuous receive test done");
    wr(`CSIO_MODE_OFS, 32'h0000_0009);
    c0 = 8'h00;
    wr(`CSIO_CTL0_OFS, 32'h0000_0000);
    wr(`CSIO_IRQST_OFS, 32'h0000_0007);
    `CHK(SCK_OE, 1'b0)
    xfer(8'hE1, 8'h1E);
    // idles high for edge select 0
    repeat (8) begin
      repeat (6) @(posedge CLK);
      SCK_I <= 1'b0;
      repeat (6) @(posedge CLK);
      SCK_I <= 1'b1;
    end
    poll(`CSIO_IRQST_OFS, `CSIO_IRQ_RX);
    rd(`CSIO_RXBUF_OFS);
    `CHK(d[7:0], 8'h1E)
    `CHK(p_rx, 8'hE1)
    $display("external clock test done");
    // reset after the external clock transfer returns SDO, SDO_OE, SCK_OE and IRQ to their idle state
    RESETN <= 1'b0;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    `CHK({SDO, SDO_OE, SCK_OE, IRQ}, 4'h8)
    rd(`CSIO_CTL1_OFS);
    `CHK(d[7:0], `CSIO_RST_C1)
    wr(`CSIO_MODE_OFS, 32'h0000_0001);
    `CHK({SDO, SDO_OE}, 2'b11)
    wr(`CSIO_CTL0_OFS, 32'h0000_0020);
    `CHK({SDO, SDO_OE}, 2'b10)
    $display("reset test done");
    conclude();
  end
endmodule // test_clocked_serial_io
